// ===== shared/port_mode_params.svh
`ifndef PORT_MODE_PARAMS_SVH
`define PORT_MODE_PARAMS_SVH

// ====================================================================
// Register offsets (byte addresses on the 8-bit register port)
`define DIR_OFS_A      8'h04
`define DIR_OFS_B      8'h05
`define DIR_OFS_C      8'h08
`define DIR_OFS_D      8'h09
`define DIR_OFS_E      8'h0C
`define DIR_OFS_F      8'h0D
`define DIR_OFS_G      8'h10
`define DIR_OFS_H      8'h11
`define DIR_OFS_LAST   8'h14
// Port latch sits two bytes below its direction register
`define LATCH_GAP      8'h02
`define MODE_OFS       8'h5E

// ====================================================================
// Field positions and reset values
`define MODE_LOW_BIT   0
`define MODE_HIGH_BIT  1
`define DIR_RST        8'h00
`define LATCH_RST      8'h00
`define MODE_RST       2'h0

// ====================================================================
// Memory regions and timing
`define INT_TOP_MICRO  24'h00027F
`define INT_BASE_EXP   24'h00C000
`define BUS_DATA_CYC   3
`define CTRL_BITS      3

`endif

// ===== shared/port_mode_pkg.sv
package port_mode_pkg;

    // Mode codes follow {high bit, low bit}
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_EXPAND = 2'h1,
        MODE_MICRO  = 2'h2,
        MODE_EVAL   = 2'h3
    } mode_e;

    typedef struct packed {
        logic        write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_s;

endpackage

// ===== rtl/port_slice.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_params.svh"

module port_slice
    import port_mode_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] padIn,
    input  wire logic         wrLatch,
    input  wire logic         wrDir,
    input  wire logic [W-1:0] wrData,
    input  wire logic [W-1:0] ovrMask,
    input  wire logic [W-1:0] ovrOut,
    input  wire logic [W-1:0] ovrOe,
    output logic      [W-1:0] readVal,
    output logic      [W-1:0] pinLevel,
    output logic      [W-1:0] padOut,
    output logic      [W-1:0] padOe
);

    logic [W-1:0] latch_r;
    logic [W-1:0] dir_r;
    logic [W-1:0] syncA_r;
    logic [W-1:0] syncB_r;

    // ================================================================
    // Pin synchroniser, two stages before any logic
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= padIn;
            syncB_r <= syncA_r;
        end
    end

    // Latch takes writes whatever the direction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch_r <= `LATCH_RST;
        end else if (wrLatch) begin
            latch_r <= wrData;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_r <= `DIR_RST;
        end else if (wrDir) begin
            dir_r <= wrData;
        end
    end

    // Registered pad drive; bus takeover wins over the port bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            padOut <= '0;
            padOe  <= '0;
        end else begin
            padOut <= (ovrMask & ovrOut) | (~ovrMask & latch_r);
            padOe  <= (ovrMask & ovrOe) | (~ovrMask & dir_r);
        end
    end

    // Output bits read the latch, so a loaded pin still reads back
    assign readVal  = (dir_r & latch_r) | (~dir_r & syncB_r);
    assign pinLevel = syncB_r;

endmodule // port_slice

`default_nettype wire

// ===== rtl/port_direction_and_bus_mode.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_params.svh"

// Operation
// - Every port bit has a direction bit; set means output, clear input.
// - Output pins store writes in the latch and drive the latch.
// - Reading an output bit returns the latch, not the pin.
// - Input pins are undriven and read the pin level.
// - Writes to input bits only update the latch; pin stays undriven.
// - Two mode bits select one of four operating modes.
// - Outside single-chip, ports a to d and part of e carry the bus.
// - External access only outside single-chip; region depends on mode.
// - Width pin high: 8-bit external data on port_c only.
// - Width pin low: 16-bit external data on port_b and port_c.
// - Internal memory accesses always use the 16-bit path.
module port_direction_and_bus_mode
    import port_mode_pkg::*;
#(
    parameter int NPORTS   = 9,
    parameter int DATA_CYC = `BUS_DATA_CYC
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic [7:0]         regAddr,
    input  wire logic [7:0]         regWdata,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic      [7:0]         regRdata,
    input  wire logic               byteWidthPin,
    input  wire logic [NPORTS-1:0][7:0] padIn,
    output logic      [NPORTS-1:0][7:0] padOut,
    output logic      [NPORTS-1:0][7:0] padOe,
    input  wire logic               accReq,
    input  wire bus_req_s           accInfo,
    output logic                    accBusy,
    output logic                    accDone,
    output logic                    accExternal,
    output logic      [15:0]        accRdata,
    output logic                    intReq,
    output bus_req_s                intInfo,
    input  wire logic [15:0]        intRdata,
    output mode_e                   modeOut
);

    // ================================================================
    // Elaboration checks
    if (NPORTS != 9) begin : gBadPorts
        $error("NPORTS must be 9");
    end
    if (DATA_CYC < 3 || DATA_CYC > 15) begin : gBadCyc
        $error("DATA_CYC must lie in 3..15");
    end

    // ================================================================
    // Register decode
    typedef struct packed {
        logic       hit;
        logic       isDir;
        logic [3:0] idx;
    } port_hit_s;

    // Shared by the write and read paths
    function automatic port_hit_s decodePort(input logic [7:0] a);
        logic [7:0] dirOfs [9];
        port_hit_s  r;
        dirOfs = '{`DIR_OFS_A, `DIR_OFS_B, `DIR_OFS_C, `DIR_OFS_D,
                   `DIR_OFS_E, `DIR_OFS_F, `DIR_OFS_G, `DIR_OFS_H,
                   `DIR_OFS_LAST};
        r = '0;
        for (int i = 0; i < 9; i++) begin
            if (a == dirOfs[i]) begin
                r = '{hit: 1'b1, isDir: 1'b1, idx: 4'(i)};
            end else if (a == dirOfs[i] - `LATCH_GAP) begin
                r = '{hit: 1'b1, isDir: 1'b0, idx: 4'(i)};
            end
        end
        return r;
    endfunction

    // Five bus states in a 3-bit code; codes 5 to 7 are unused
    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_DATA,
        BUS_INT,
        BUS_DONE
    } bus_state_e;

    port_hit_s  wrHit;
    port_hit_s  rdHit;
    logic [1:0] mode_r;
    mode_e      mode;
    logic       widthSyncA_r;
    logic       widthSync_r;
    bus_state_e state_r;
    bus_state_e state_nxt;
    bus_req_s   req_r;
    logic       byteBus_r;
    logic [3:0] cyc_r;
    logic       busOwned;
    logic       targetExternal;

    logic [NPORTS-1:0][7:0] readVal;
    logic [NPORTS-1:0][7:0] pinLevel;
    logic [NPORTS-1:0][7:0] ovrMask;
    logic [NPORTS-1:0][7:0] ovrOut;
    logic [NPORTS-1:0][7:0] ovrOe;
    logic [NPORTS-1:0]      wrLatch;
    logic [NPORTS-1:0]      wrDir;

    assign wrHit = decodePort(regAddr);
    assign rdHit = decodePort(regRead ? regAddr : 8'h00);
    assign mode  = mode_e'(mode_r);

    // ================================================================
    // Processor mode register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_r <= `MODE_RST;
        end else if (regWrite && regAddr == `MODE_OFS) begin
            mode_r <= {regWdata[`MODE_HIGH_BIT],
                       regWdata[`MODE_LOW_BIT]};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeOut <= MODE_SINGLE;
        end else begin
            modeOut <= mode;
        end
    end

    // Width pin comes from the board, two stages first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            widthSyncA_r <= 1'b0;
            widthSync_r  <= 1'b0;
        end else begin
            widthSyncA_r <= byteWidthPin;
            widthSync_r  <= widthSyncA_r;
        end
    end

    // ================================================================
    // Port slices
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : gPort
            assign wrLatch[gp] = regWrite && wrHit.hit && !wrHit.isDir
                                 && wrHit.idx == 4'(gp);
            assign wrDir[gp]   = regWrite && wrHit.hit && wrHit.isDir
                                 && wrHit.idx == 4'(gp);
            port_slice #(
                .W       (8)
            ) uSlice (
                .mclk    (mclk),
                .rst     (rst),
                .padIn   (padIn[gp]),
                .wrLatch (wrLatch[gp]),
                .wrDir   (wrDir[gp]),
                .wrData  (regWdata),
                .ovrMask (ovrMask[gp]),
                .ovrOut  (ovrOut[gp]),
                .ovrOe   (ovrOe[gp]),
                .readVal (readVal[gp]),
                .pinLevel(pinLevel[gp]),
                .padOut  (padOut[gp]),
                .padOe   (padOe[gp])
            );
        end
    endgenerate

    // ================================================================
    // Register read, data one cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            if (rdHit.hit) begin
                regRdata <= rdHit.isDir ? 8'h00 : readVal[rdHit.idx];
                if (rdHit.isDir) begin
                    regRdata <= 8'h00;
                end
            end else if (regAddr == `MODE_OFS) begin
                regRdata <= {6'h00, mode_r};
            end else begin
                regRdata <= 8'h00;
            end
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ================================================================
    // Region decode: internal or external target
    always_comb begin
        unique case (mode)
            MODE_SINGLE: targetExternal = 1'b0;
            MODE_EXPAND: targetExternal =
                accInfo.addr < 24'h000080
                || (accInfo.addr > `INT_TOP_MICRO
                    && accInfo.addr < `INT_BASE_EXP)
                || accInfo.addr[23:16] != 8'h00;
            MODE_MICRO,
            MODE_EVAL:   targetExternal =
                accInfo.addr > `INT_TOP_MICRO;
        endcase
    end

    // Bus owns the low ports in every mode but single-chip
    assign busOwned = (mode != MODE_SINGLE);

    // ================================================================
    // Access sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BUS_IDLE: begin
                if (accReq) begin
                    state_nxt = targetExternal ? BUS_ADDR : BUS_INT;
                end
            end
            BUS_ADDR: state_nxt = BUS_DATA;
            BUS_DATA: begin
                if (cyc_r == 4'(DATA_CYC)) begin
                    state_nxt = BUS_DONE;
                end
            end
            BUS_INT:  state_nxt = BUS_DONE;
            BUS_DONE: state_nxt = BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request captured once; width fixed for the whole access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_r     <= '0;
            byteBus_r <= 1'b0;
        end else if (state_r == BUS_IDLE && accReq) begin
            req_r     <= accInfo;
            byteBus_r <= widthSync_r;
        end
    end

    // One extra data cycle: pad register plus two sync stages lag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cyc_r <= 4'h0;
        end else if (state_r == BUS_DATA) begin
            cyc_r <= cyc_r + 4'h1;
        end else begin
            cyc_r <= 4'h0;
        end
    end

    // Internal path is always a full 16-bit word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            intReq  <= 1'b0;
            intInfo <= '0;
        end else begin
            intReq  <= (state_r == BUS_IDLE) && accReq
                       && !targetExternal;
            if (state_r == BUS_IDLE && accReq) begin
                intInfo <= accInfo;
            end
        end
    end

    // Completion and read data
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            accDone     <= 1'b0;
            accRdata    <= 16'h0000;
            accExternal <= 1'b0;
        end else begin
            accDone <= (state_nxt == BUS_DONE) && (state_r != BUS_DONE);
            if (state_r == BUS_IDLE && accReq) begin
                accExternal <= targetExternal;
            end
            if (state_r == BUS_INT) begin
                accRdata <= intRdata;
            end else if (state_r == BUS_DATA
                         && cyc_r == 4'(DATA_CYC) && !req_r.write) begin
                if (byteBus_r) begin
                    accRdata <= {8'h00, pinLevel[2]};
                end else begin
                    accRdata <= {pinLevel[1], pinLevel[2]};
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            accBusy <= 1'b0;
        end else begin
            accBusy <= (state_nxt != BUS_IDLE);
        end
    end

    // ================================================================
    // Pin takeover: a=A7..0, d=A15..8, b=A23..16 then high data,
    // c=low data, e[0]=read strobe low, e[1]=write strobe low,
    // e[2]=address latch enable
    always_comb begin
        logic ext;
        logic addrPh;
        logic dataPh;
        ext     = (state_r == BUS_ADDR) || (state_r == BUS_DATA);
        addrPh  = (state_r == BUS_ADDR);
        dataPh  = (state_r == BUS_DATA);
        ovrMask = '0;
        ovrOut  = '0;
        ovrOe   = '0;
        if (busOwned) begin
            ovrMask[0] = 8'hFF;
            ovrMask[1] = 8'hFF;
            ovrMask[2] = 8'hFF;
            ovrMask[3] = 8'hFF;
            ovrMask[4] = 8'h07;
            ovrOut[0]  = req_r.addr[7:0];
            ovrOe[0]   = 8'hFF;
            ovrOut[3]  = req_r.addr[15:8];
            ovrOe[3]   = 8'hFF;
            // Address high shares port_b with the upper data byte
            if (addrPh || byteBus_r) begin
                ovrOut[1] = req_r.addr[23:16];
                ovrOe[1]  = 8'hFF;
            end else if (dataPh && req_r.write) begin
                ovrOut[1] = req_r.wdata[15:8];
                ovrOe[1]  = 8'hFF;
            end
            if (dataPh && req_r.write) begin
                ovrOut[2] = req_r.wdata[7:0];
                ovrOe[2]  = 8'hFF;
            end
            ovrOut[4][0] = !(dataPh && !req_r.write);
            ovrOut[4][1] = !(dataPh && req_r.write);
            ovrOut[4][2] = addrPh;
            ovrOe[4]     = 8'h07;
            if (!ext) begin
                ovrOe[0] = 8'hFF;
            end
        end
    end

endmodule // port_direction_and_bus_mode

`default_nettype wire

// ===== tb/port_mode_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_params.svh"

// ========
// Checker on the top ports
module port_mode_checker
    import port_mode_pkg::*;
#(
    parameter int NPORTS   = 9,
    parameter int DATA_CYC = 3
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic [7:0]              regAddr,
    input wire logic [7:0]              regWdata,
    input wire logic                    regWrite,
    input wire logic                    regRead,
    input wire logic [7:0]              regRdata,
    input wire logic                    byteWidthPin,
    input wire logic [NPORTS-1:0][7:0]  padOut,
    input wire logic [NPORTS-1:0][7:0]  padOe,
    input wire logic                    accReq,
    input wire bus_req_s                accInfo,
    input wire logic                    accBusy,
    input wire logic                    accDone,
    input wire logic                    accExternal,
    input wire logic                    intReq,
    input wire bus_req_s                intInfo,
    input wire mode_e                   modeOut
);
    localparam int EXT_LAT = DATA_CYC + 3;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Accepted requests; addresses above 64K are external in bus modes
    sequence s_take;
        accReq && !accBusy;
    endsequence
    sequence s_int_take;
        s_take ##0 modeOut == MODE_SINGLE;
    endsequence
    sequence s_ext_take;
        s_take ##0 (modeOut != MODE_SINGLE && accInfo.addr > 24'h00FFFF);
    endsequence

    property p_reset;
        $fell(rst) |-> padOe == '0 && modeOut == MODE_SINGLE;
    endproperty
    property p_rd_idle;
        !regRead |=> regRdata == 8'h00;
    endproperty
    property p_dir_wo;
        regRead && regAddr == `DIR_OFS_A |=> regRdata == 8'h00;
    endproperty
    // Port f is never bus-owned, so it is safe in every mode
    property p_dir_oe;
        regWrite && regAddr == `DIR_OFS_F
            |-> ##2 padOe[5] == $past(regWdata, 2);
    endproperty
    property p_latch_out;
        regWrite && regAddr == (`DIR_OFS_F - `LATCH_GAP)
            |-> ##2 (padOut[5] & padOe[5]) == ($past(regWdata, 2) & padOe[5]);
    endproperty
    property p_int_path;
        s_int_take |-> ##2 (accDone && !accExternal);
    endproperty
    property p_int_req;
        s_int_take |=> (intReq && intInfo == $past(accInfo));
    endproperty
    property p_ext_done;
        s_ext_take |-> ##EXT_LAT (accDone && accExternal);
    endproperty
    property p_addr_out;
        s_ext_take |-> ##2 (padOe[4][2] && padOut[4][2]
            && padOut[0] == $past(accInfo.addr[7:0], 2)
            && padOut[3] == $past(accInfo.addr[15:8], 2));
    endproperty
    property p_byte8;
        s_ext_take ##0 (accInfo.write && byteWidthPin)
            |-> ##3 (padOe[2] == 8'hFF
            && padOut[2] == $past(accInfo.wdata[7:0], 3));
    endproperty
    property p_word16;
        s_ext_take ##0 (accInfo.write && !byteWidthPin)
            |-> ##3 (padOut[1] == $past(accInfo.wdata[15:8], 3)
            && padOut[2] == $past(accInfo.wdata[7:0], 3));
    endproperty

    a_reset: assert property (p_reset)
        else $error("pins driven after reset");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    a_dir_wo: assert property (p_dir_wo)
        else $error("direction read not zero");
    a_dir_oe: assert property (p_dir_oe)
        else $error("enable does not follow direction");
    a_latch_out: assert property (p_latch_out)
        else $error("output pins not latch");
    a_int_path: assert property (p_int_path)
        else $error("internal access timing");
    a_int_req: assert property (p_int_req)
        else $error("internal request not issued");
    a_ext_done: assert property (p_ext_done)
        else $error("external access timing");
    a_addr_out: assert property (p_addr_out)
        else $error("address pins wrong");
    a_byte8: assert property (p_byte8)
        else $error("byte bus data wrong");
    a_word16: assert property (p_word16)
        else $error("word bus data wrong");
endmodule // port_mode_checker

bind port_direction_and_bus_mode port_mode_checker #(
    .NPORTS(NPORTS), .DATA_CYC(DATA_CYC)) port_mode_checker_i (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .byteWidthPin(byteWidthPin), .padOut(padOut), .padOe(padOe),
    .accReq(accReq), .accInfo(accInfo), .accBusy(accBusy),
    .accDone(accDone), .accExternal(accExternal), .intReq(intReq),
    .intInfo(intInfo), .modeOut(modeOut));
`default_nettype wire

// ===== tb/board_model.sv
`timescale 1ns/100ps
`default_nettype none

// ========
// Board: loads on driven pins, sources on floating ones
module board_model #(
    parameter int NPORTS = 9
) (
    input  wire logic [NPORTS-1:0][7:0] padOut,
    input  wire logic [NPORTS-1:0][7:0] padOe,
    input  wire logic [NPORTS-1:0][7:0] extLvl,
    input  wire logic                   disturb,
    output logic      [NPORTS-1:0][7:0] padIn
);
    // A heavy load may flip a driven level; floating pins see the board
    assign padIn = (padOe & (padOut ^ {NPORTS*8{disturb}}))
                 | (~padOe & extLvl);
endmodule // board_model
`default_nettype wire

// ===== tb/port_direction_and_bus_mode_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_params.svh"

// ========
// Bench
module port_direction_and_bus_mode_tb
    import port_mode_pkg::*;
;
    localparam int NP = 9;
    localparam logic [7:0] DOFS [NP] = '{`DIR_OFS_A, `DIR_OFS_B,
        `DIR_OFS_C, `DIR_OFS_D, `DIR_OFS_E, `DIR_OFS_F, `DIR_OFS_G,
        `DIR_OFS_H, `DIR_OFS_LAST};
    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          regAddr = 8'h00;
    logic [7:0]          regWdata = 8'h00;
    logic                regWrite = 1'b0;
    logic                regRead = 1'b0;
    logic [7:0]          regRdata;
    logic                byteWidthPin = 1'b0;
    logic [NP-1:0][7:0]  padIn;
    logic [NP-1:0][7:0]  padOut;
    logic [NP-1:0][7:0]  padOe;
    logic [NP-1:0][7:0]  extLvl = '0;
    logic                disturb = 1'b0;
    logic                accReq = 1'b0;
    bus_req_s            accInfo = '0;
    logic                accBusy;
    logic                accDone;
    logic                accExternal;
    logic [15:0]         accRdata;
    logic                intReq;
    bus_req_s            intInfo;
    logic [15:0]         intRdata = 16'h0000;
    mode_e               modeOut;
    int                  miscompares = 0;
    int                  nChecks = 0;
    int                  dirM [NP];

    always #20 mclk = ~mclk;

    port_direction_and_bus_mode #(.NPORTS(NP), .DATA_CYC(3))
        port_direction_and_bus_mode_i (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .byteWidthPin(byteWidthPin), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .accReq(accReq), .accInfo(accInfo),
        .accBusy(accBusy), .accDone(accDone), .accExternal(accExternal),
        .accRdata(accRdata), .intReq(intReq), .intInfo(intInfo),
        .intRdata(intRdata), .modeOut(modeOut));
    board_model #(.NPORTS(NP)) board_model_i (.padOut(padOut),
        .padOe(padOe), .extLvl(extLvl), .disturb(disturb), .padIn(padIn));

    // ========
    // Tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic acc(logic w, logic [23:0] a, logic [15:0] wd,
                       output logic [15:0] q);
        int n;
        @(posedge mclk);
        accReq <= 1'b1;
        accInfo <= {w, a, wd};
        @(posedge mclk);
        accReq <= 1'b0;
        n = 0;
        #1;
        cmp("accBusy", 16'h0001, {15'h0, accBusy});
        while (accDone !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (accDone !== 1'b1) begin
            cmp("accDone", 16'h0001, 16'h0000);
            end_sim();
        end
        q = accRdata;
    endtask

    // ========
    // Main sequence
    initial begin
        int i;
        int d;
        int l;
        int e;
        int m;
        int w;
        logic [7:0] r;
        logic [15:0] v;
        logic [15:0] q;
        logic [15:0] x;
        d = $urandom(32'h63BC782E);
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1 cmp("padOeAny", 16'h0000, {15'h0, |padOe});
        cmp("modeOut", 16'h0000, 16'(modeOut));
        for (i = 0; i < NP; i++) begin
            dirM[i] = 0;
        end
        // Latch first while still input, then turn to output
        for (i = 0; i < NP; i++) begin
            l = $urandom_range(255, 0);
            d = $urandom_range(255, 0);
            e = $urandom_range(255, 0);
            extLvl[i] <= 8'(e);
            wr(DOFS[i] - `LATCH_GAP, 8'(l));
            repeat (2) @(posedge mclk);
            #1 cmp("padOeHeld", 16'(dirM[i]), 16'(padOe[i]));
            wr(DOFS[i], 8'(d));
            dirM[i] = d;
            disturb <= 1'b1;
            repeat (4) @(posedge mclk);
            #1 cmp("padOe", 16'(d), 16'(padOe[i]));
            cmp("padOut", 16'(l & d), 16'(padOut[i] & 8'(d)));
            rd(DOFS[i] - `LATCH_GAP, r);
            cmp("portRead", 16'((l & d) | (e & ~d)), 16'(r));
            rd(DOFS[i], r);
            cmp("dirRead", 16'h0000, 16'(r));
            disturb <= 1'b0;
        end
        // Release every pin: all direction registers back to input
        for (i = 0; i < NP; i++) begin
            wr(DOFS[i], 8'h00);
        end
        repeat (3) @(posedge mclk);
        #1 cmp("padOeAny", 16'h0000, {15'h0, |padOe});
        for (m = 0; m < 4; m++) begin
            wr(`MODE_OFS, 8'(m));
            repeat (2) @(posedge mclk);
            rd(`MODE_OFS, r);
            cmp("modeOut", 16'(m), 16'(modeOut));
            cmp("modeReg", 16'(m), 16'(r[1:0]));
            for (w = 0; w < 2; w++) begin
                v = 16'($urandom_range(65535, 0));
                x = 16'($urandom_range(65535, 0));
                byteWidthPin <= (w == 1);
                intRdata <= v;
                extLvl[1] <= x[15:8];
                extLvl[2] <= x[7:0];
                repeat (4) @(posedge mclk);
                acc(1'b0, 24'h000100, 16'h0000, q);
                cmp("intRead", v, q);
                cmp("intAddr", 16'h0100, intInfo.addr[15:0]);
                cmp("accExt", 16'h0000, {15'h0, accExternal});
                acc(1'b1, 24'h010000 | 24'(v), x, q);
                cmp("accExt", 16'(m != 0), {15'h0, accExternal});
                acc(1'b0, 24'h012345, 16'h0000, q);
                if (m == 0) begin
                    cmp("singleRead", v, q);
                end else if (w == 1) begin
                    cmp("byteRead", {8'h00, x[7:0]}, q);
                end else begin
                    cmp("wordRead", x, q);
                end
            end
        end
        end_sim();
    end
endmodule // port_direction_and_bus_mode_tb
`default_nettype wire
